/* core/enc_port_pkg.sv */
// Shared constants and types for the encoder position readout port.
// Assumes a 100 MHz core clock and a link clock well below 10 MHz.
package enc_port_pkg;

   // ****************************************
   // Clock rate and link timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;      // Core clock period in ns.
   localparam int TOUT_SSI_NS = 7000;      // Synchronous serial timeout.
   localparam int TOUT_BISS_NS = 18000;    // BiSS timeout, delay comp.
   localparam int BUSY_NS = 7500;          // BiSS busy time, typical.
   // Longest times round down, least times round up.
   localparam int TOUT_SSI_CYC = TOUT_SSI_NS / CLK_PERIOD_NS;
   localparam int TOUT_BISS_CYC = TOUT_BISS_NS / CLK_PERIOD_NS;
   localparam int BUSY_CYC = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 11;              // Wide enough for every count.
   localparam int EDGE_LAT_CYC = 4;        // Pin edge to load, plus flop.

   // ****************************************
   // Frame layout
   // ****************************************
   localparam int TURN_W = 16;             // Multiturn count width.
   localparam int ANGLE_W = 17;            // Singleturn angle width.
   localparam int LEAD_ZEROS = 8;          // Leading zeros, serial mode.
   localparam int CRC_W = 6;               // BiSS CRC width.
   localparam int FRAME_W = 43;            // Longest frame, BiSS.
   localparam int SSI_BITS = LEAD_ZEROS + TURN_W + ANGLE_W;
   localparam int BISS_BITS = 2 + TURN_W + ANGLE_W + 2 + CRC_W;
   localparam int DATA_W = TURN_W + ANGLE_W + 2;   // Bits under the CRC.
   localparam logic [5:0] CRC_POLY = 6'h03; // x^6 + x + 1, top bit implied.
   localparam logic [5:0] SSI_PAD = 6'h00;  // Fill below a serial frame.
   localparam logic [1:0] START_CDS = 2'h2; // Start bit one, slot bit zero.

   // Factory protocol choice.
   typedef enum logic {PROTO_SSI, PROTO_BISS} proto_t;

   // One position sample.
   typedef struct packed {
      logic [TURN_W-1:0] turns;            // Revolution count.
      logic [ANGLE_W-1:0] angle;           // Aligned angle.
   } pos_t;

endpackage : enc_port_pkg

/* core/absolute_encoder_position_port.sv */
// Serial position readout port of an absolute multiturn encoder.
// Assumes the sensing logic delivers turns and raw angle on core_clk and
// that the link clock and protocol strap arrive from outside the domain.
`timescale 1ns/100ps

// Function
// RL1 - Report 16-bit turns and 17-bit angle.
// RL2 - Turn count spans all 65536 revolutions.
// RL3 - Master clocks within the mode's frequency band.
// RL4 - BiSS timeout never exceeds 18 us.
// RL5 - Angle increases with clockwise shaft rotation.
// RL6 - Angle zero equals commutation zero point.
// RL7 - Angle passes zero once per revolution.
// RL8 - Serial frame: eight zeros, turns, angle.
// RL9 - BiSS frame: header, turns, angle, flags, CRC.
// RL10 - Master waits beyond timeout before next read.
// RL11 - Master allows 50 us per serial read.
// RL12 - Sample captured at frame start, held throughout.
module absolute_encoder_position_port (
   input wire logic core_clk,                        // Core clock, 100 MHz.
   input wire logic rst_n,                           // Async reset, low.
   input wire logic linkClk,                         // Clock from master.
   input wire logic protoBiss,                       // Strap, high for BiSS.
   input wire logic [enc_port_pkg::TURN_W-1:0] turnCount,  // Turns.
   input wire logic [enc_port_pkg::ANGLE_W-1:0] rawAngle,  // Raw, CW up.
   input wire logic [enc_port_pkg::ANGLE_W-1:0] zeroOffset, // Zero point.
   input wire logic errorFlag,                       // Error bit value.
   input wire logic warnFlag,                        // Warning bit value.
   output logic linkData,                            // Serial data line.
   output logic linkReady                            // High when idle.
);
   import enc_port_pkg::*;

   // ****************************************
   // Reset release and input synchronisers
   // ****************************************
   logic [1:0] rstSync;       // Reset release chain.
   logic rstSyncN;            // Synchronised reset used by the design.
   logic [1:0] clkSync;       // Link clock chain, bit 0 is the first stage.
   logic clkPrev;             // Delayed synchronised link clock.
   logic [1:0] strapSync;     // Protocol strap chain.
   logic strapTaken;          // Strap has been latched.
   proto_t proto;             // Latched protocol.
   logic riseEv;              // Link clock rising edge.
   logic fallEv;              // Link clock falling edge.

   // Reset is asserted at once and released through two flip-flops.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstSyncN = rstSync[1];

   // Only the second stage and later feed any logic.
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         clkSync <= 2'h3;
         clkPrev <= 1'b1;
      end else begin
         clkSync <= {clkSync[0], linkClk};
         clkPrev <= clkSync[1];
      end
   end

   // The strap chain has no reset, so it already holds the strap level
   // when the reset lifts and the latch below takes it.
   always_ff @(posedge core_clk) begin
      strapSync <= {strapSync[0], protoBiss};
   end
   assign riseEv = clkSync[1] && !clkPrev;
   assign fallEv = !clkSync[1] && clkPrev;

   // The strap is caught once, after the release, and then held.
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         strapTaken <= 1'b0;
         proto <= PROTO_SSI;
      end else if (!strapTaken) begin
         strapTaken <= 1'b1;
         proto <= strapSync[1] ? PROTO_BISS : PROTO_SSI;
      end
   end

   // ****************************************
   // Angle alignment
   // ****************************************
   logic [ANGLE_W-1:0] alignedAngle;       // Angle relative to zero point.
   logic [ANGLE_W-1:0] next_alignedAngle;  // Next aligned angle.

   // Subtracting the factory zero keeps the raw counting sense, so the
   // value still rises clockwise and wraps once per turn.
   always_comb begin
      next_alignedAngle = rawAngle - zeroOffset; // RL5 RL6 RL7
   end

   // Registers the aligned angle.
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         alignedAngle <= '0;
      end else begin
         alignedAngle <= next_alignedAngle;
      end
   end

   // ****************************************
   // CRC over turns, angle and flags
   // ****************************************
   // Serial CRC, MSB first, zero seed; the line carries its inverse.
   function automatic logic [CRC_W-1:0] crc6(input logic [DATA_W-1:0] d);
      logic [CRC_W-1:0] c;
      logic fb;
      c = '0;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         fb = c[CRC_W-1] ^ d[i];
         c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
      end
      return c;
   endfunction : crc6

   // ****************************************
   // Frame sequencer
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SHIFT, ST_TAIL} state_t;
   state_t state;                 // Sequencer state.
   state_t next_state;            // Next state.
   pos_t snap;                    // Position held for the frame.
   pos_t next_snap;               // Next held position.
   logic [FRAME_W-1:0] frame;     // Outgoing bits, MSB goes first.
   logic [FRAME_W-1:0] next_frame;
   logic [5:0] bitsLeft;          // Bits still to send.
   logic [5:0] next_bitsLeft;
   logic [CNT_W-1:0] busyCnt;     // BiSS busy countdown.
   logic [CNT_W-1:0] next_busyCnt;
   logic [CNT_W-1:0] toutCnt;     // Timeout since last link edge.
   logic [CNT_W-1:0] next_toutCnt;
   logic next_linkData;           // Next data line level.
   logic next_linkReady;          // Next ready level.
   logic capture;                 // Frame start seen.
   logic [CNT_W-1:0] toutLoad;    // Timeout for the latched protocol.
   logic [DATA_W-1:0] crcData;    // Bits covered by the CRC.

   assign capture = (state == ST_IDLE) && fallEv && strapTaken;
   // The load leaves room for edge detection and the output flop, so the
   // line is freed within the limit counted from the pin edge.
   assign toutLoad = (proto == PROTO_BISS)
      ? CNT_W'(TOUT_BISS_CYC - EDGE_LAT_CYC)
      : CNT_W'(TOUT_SSI_CYC - EDGE_LAT_CYC); // RL4
   assign crcData = {turnCount, alignedAngle, errorFlag, warnFlag};

   // Computes the next state of the whole frame sequencer.
   always_comb begin
      next_state = state;
      next_snap = snap;
      next_frame = frame;
      next_bitsLeft = bitsLeft;
      next_busyCnt = (busyCnt != '0) ? busyCnt - CNT_W'(1) : busyCnt;
      next_linkData = linkData;
      // Any link edge restarts the timeout; it runs down otherwise.
      if (riseEv || fallEv) begin
         next_toutCnt = toutLoad;
      end else if (toutCnt != '0) begin
         next_toutCnt = toutCnt - CNT_W'(1);
      end else begin
         next_toutCnt = toutCnt;
      end
      unique case (state)
         ST_IDLE: begin
            next_linkData = 1'b1;
            if (capture) begin
               // One sample per frame, taken at its first edge.
               next_snap = {turnCount, alignedAngle}; // RL1 RL2 RL12
               if (proto == PROTO_BISS) begin
                  next_frame = {START_CDS, crcData,
                     ~crc6(crcData)}; // RL9
                  next_bitsLeft = 6'(BISS_BITS);
                  next_busyCnt = CNT_W'(BUSY_CYC);
                  next_state = ST_BUSY;
               end else begin
                  next_frame = {8'h00, turnCount, alignedAngle,
                     SSI_PAD[1:0]}; // RL8
                  next_bitsLeft = 6'(SSI_BITS);
                  next_state = ST_SHIFT;
               end
            end
         end
         ST_BUSY: begin
            // Acknowledge and busy hold the line low.
            if (riseEv) begin
               next_linkData = 1'b0;
               if (busyCnt == '0) begin
                  next_state = ST_SHIFT;
               end
            end
         end
         ST_SHIFT: begin
            // Each rising link edge presents the next bit.
            if (riseEv) begin
               if (bitsLeft == '0) begin
                  next_linkData = 1'b0;
                  next_state = ST_TAIL;
               end else begin
                  next_linkData = frame[FRAME_W-1];
                  next_frame = {frame[FRAME_W-2:0], 1'b0};
                  next_bitsLeft = bitsLeft - 6'h01;
               end
            end
         end
         ST_TAIL: begin
            next_linkData = 1'b0;
         end
      endcase
      // A silent link for the timeout ends any frame and frees the line.
      if (state != ST_IDLE && toutCnt == '0 && !riseEv && !fallEv) begin
         next_state = ST_IDLE; // RL4
         next_linkData = 1'b1;
      end
      next_linkReady = (next_state == ST_IDLE);
   end

   // Registers the frame sequencer.
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state <= ST_IDLE;
         snap <= '0;
         frame <= '0;
         bitsLeft <= 6'h00;
         busyCnt <= '0;
         toutCnt <= '0;
         linkData <= 1'b1;
         linkReady <= 1'b0;
      end else begin
         state <= next_state;
         snap <= next_snap;
         frame <= next_frame;
         bitsLeft <= next_bitsLeft;
         busyCnt <= next_busyCnt;
         toutCnt <= next_toutCnt;
         linkData <= next_linkData;
         linkReady <= next_linkReady;
      end
   end

   // ****************************************
   // Assertions and cover points
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstSyncN);

   a_snap_content: assert property (capture |=> // RL1
      snap == {$past(turnCount), $past(alignedAngle)})
      else $error("Captured sample differs from position.");
   a_turns_in_frame: assert property (capture && proto == PROTO_BISS |=> // RL2
      frame[40:25] == $past(turnCount))
      else $error("Turn count misplaced in frame.");
   a_timeout_bound: assert property ( // RL4
      toutCnt <= CNT_W'(TOUT_BISS_CYC - EDGE_LAT_CYC))
      else $error("Timeout load exceeds limit.");
   a_timeout_frees: assert property (state != ST_IDLE && toutCnt == '0 // RL4
      && !riseEv && !fallEv |=> state == ST_IDLE && linkData && linkReady)
      else $error("Timeout not honoured.");
   a_angle_cw_up: assert property ($stable(zeroOffset) && // RL5
      rawAngle == $past(rawAngle) + 17'h00001 |=>
      alignedAngle == $past(alignedAngle) + 17'h00001)
      else $error("Angle does not rise clockwise.");
   a_zero_align: assert property (rawAngle == zeroOffset |=> // RL6
      alignedAngle == '0)
      else $error("Zero not at commutation zero.");
   a_zero_once: assert property (rawAngle != zeroOffset |=> // RL7
      alignedAngle != '0)
      else $error("Angle zero away from zero point.");
   a_ssi_layout: assert property (capture && proto == PROTO_SSI |=> // RL8
      frame[42:35] == 8'h00 && frame[34:2] == snap
      && bitsLeft == 6'(SSI_BITS))
      else $error("Serial frame layout wrong.");
   a_biss_layout: assert property (capture && proto == PROTO_BISS |=> // RL9
      frame[42:41] == START_CDS && frame[5:0] == ~crc6(frame[40:6])
      && bitsLeft == 6'(BISS_BITS))
      else $error("BiSS frame layout wrong.");
   a_snap_held: assert property (state != ST_IDLE |=> // RL12
      $stable(snap))
      else $error("Sample changed during frame.");

   c_ssi_frame: cover property (state == ST_SHIFT && proto == PROTO_SSI
      ##1 state == ST_TAIL);
   c_biss_frame: cover property (state == ST_BUSY ##[1:1000]
      state == ST_SHIFT);
   c_abort: cover property (state == ST_SHIFT ##1 state == ST_IDLE);

endmodule : absolute_encoder_position_port

/* tb/link_master.sv */
// Link master model that clocks frames out of the encoder position port.
// Assumes the port samples linkClk with its own core clock.
`timescale 1ns/100ps

module link_master (
   output logic linkClk,       // Link clock to the port, idle high.
   input wire logic linkData   // Serial data from the port.
);

   // ****************************************
   // Frame clocking
   // ****************************************

   // The clock rests high between frames.
   initial begin
      linkClk = 1'b1;
   end

   // Clocks n bits at the given half period and returns them MSB first.
   // Each bit is sampled just before the next falling edge, where it
   // has long settled. With keepLow the clock stays low for a next call.
   task automatic clockBits(input int n, input logic keepLow,
                            input real halfNs, output logic [63:0] bits);
      bits = '0;
      if (linkClk === 1'b1) linkClk = 1'b0;
      for (int k = 1; k <= n; k++) begin
         #(halfNs) linkClk = 1'b1;
         #(halfNs - 0.5) bits = {bits[62:0], linkData};
         #0.5;
         if (k < n || keepLow) linkClk = 1'b0;
      end
   endtask : clockBits

   // Clocks single bits until the start bit shows, then the 42 bits
   // that follow it. The wait is bounded so a dead port cannot hang.
   task automatic readBiss(input real halfNs, output logic [63:0] bits,
                           output int waits);
      logic [63:0] one;
      waits = 0;
      one = '0;
      while (one[0] !== 1'b1 && waits < 200) begin
         clockBits(1, 1'b1, halfNs, one);
         waits++;
      end
      clockBits(42, 1'b0, halfNs, bits);
   endtask : readBiss

endmodule : link_master

/* tb/absolute_encoder_position_port_test.sv */
// Self-checking bench for the encoder position readout port.
// Assumes the link master model drives linkClk and reads linkData.
`timescale 1ns/100ps

module absolute_encoder_position_port_test;
   import enc_port_pkg::*;

   // ****************************************
   // Stimulus, instances and checking
   // ****************************************
   logic core_clk;                  // Core clock, 100 MHz.
   logic rst_n;                     // Reset, active low.
   logic protoBiss;                 // Protocol strap.
   logic errorFlag;                 // Error bit value.
   logic warnFlag;                  // Warning bit value.
   logic [TURN_W-1:0] turnCount;    // Turn count from sensing.
   logic [ANGLE_W-1:0] rawAngle;    // Raw angle from sensing.
   logic [ANGLE_W-1:0] zeroOffset;  // Factory zero point.
   wire linkClk;                    // Link clock from the model.
   wire linkData;                   // Serial data from the port.
   wire linkReady;                  // Port idle flag.
   int failures;                    // Mismatches seen.
   int checks;                      // Comparisons made.

   absolute_encoder_position_port dut_u (.core_clk(core_clk),
      .rst_n(rst_n), .linkClk(linkClk), .protoBiss(protoBiss),
      .turnCount(turnCount), .rawAngle(rawAngle), .zeroOffset(zeroOffset),
      .errorFlag(errorFlag), .warnFlag(warnFlag), .linkData(linkData),
      .linkReady(linkReady));

   link_master mst_u (.linkClk(linkClk), .linkData(linkData));

   // Core clock, 10 ns period.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Compares a frame word.
   task automatic cmpWord(input logic [63:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask : cmpWord

   // Compares a single flag.
   task automatic cmpFlag(input logic got, exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s %b not %b", $time, what, got, exp);
      end
   endtask : cmpFlag

   // Resets the port with a new strap and checks the idle levels.
   task automatic resetPort(input logic biss);
      rst_n <= 1'b0;
      protoBiss <= biss;
      repeat (10) @(posedge core_clk);
      cmpFlag(linkData, 1'b1, "data in reset");
      cmpFlag(linkReady, 1'b0, "ready in reset");
      rst_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      cmpFlag(linkReady, 1'b1, "ready after reset");
   endtask : resetPort

   // Waits, bounded, for the port to report idle again.
   task automatic waitReady(input int limit);
      int n;
      n = 0;
      while (linkReady !== 1'b1 && n < limit) begin
         @(posedge core_clk);
         n++;
      end
      cmpFlag(linkReady, 1'b1, "ready after timeout");
      cmpFlag(linkData, 1'b1, "data idles high");
   endtask : waitReady

   // Serial mode: full frame, held sample, aborted frame, new sample.
   task automatic testSsi;
      logic [63:0] bits;
      resetPort(1'b0);
      turnCount <= 16'hffff;
      rawAngle <= 17'h00005;
      zeroOffset <= 17'h00010;
      repeat (2) @(posedge core_clk);
      fork
         mst_u.clockBits(42, 1'b0, 500.0, bits);
         begin
            repeat (300) @(posedge core_clk);
            cmpFlag(linkReady, 1'b0, "busy in frame");
            turnCount <= 16'h0001;
            rawAngle <= 17'h1fffe;
            @(posedge core_clk);
            rawAngle <= 17'h1ffff;
         end
      join
      cmpWord(bits, {22'h0, 8'h00, 16'hffff, 17'h1fff5, 1'b0}, "ssi");
      waitReady(TOUT_SSI_CYC);
      #20000;
      mst_u.clockBits(10, 1'b0, 500.0, bits);
      repeat (20) @(posedge core_clk);
      cmpFlag(linkReady, 1'b0, "busy after abort");
      waitReady(TOUT_SSI_CYC);
      #20000;
      mst_u.clockBits(41, 1'b0, 500.0, bits);
      cmpWord(bits, {23'h0, 8'h00, 16'h0001, 17'h1ffef}, "ssi 2");
      waitReady(TOUT_SSI_CYC);
      $display("test ssi done");
   endtask : testSsi

   // BiSS mode: busy bits, header, data, flags and inverted CRC.
   task automatic testBiss(input logic err, warn);
      logic [63:0] bits;
      logic [34:0] load;
      logic [5:0] crc;
      int waits;
      resetPort(1'b1);
      turnCount <= 16'h8001;
      rawAngle <= 17'h10000;
      zeroOffset <= 17'h00000;
      errorFlag <= err;
      warnFlag <= warn;
      repeat (2) @(posedge core_clk);
      load = {16'h8001, 17'h10000, err, warn};
      crc = 6'h00;
      for (int i = 34; i >= 0; i--) begin
         crc = {crc[4:0], 1'b0} ^ ((crc[5] ^ load[i]) ? CRC_POLY : 6'h00);
      end
      mst_u.readBiss(100.0, bits, waits);
      cmpFlag(waits >= 30 && waits < 200, 1'b1, "busy length");
      cmpWord(bits, {22'h0, 1'b0, load, ~crc}, "biss");
      waitReady(TOUT_BISS_CYC);
      #25000;
      $display("test biss done");
   endtask : testBiss

   // Watchdog: the tests take about 300 us, so 600 us means a hang.
   initial begin
      #600000;
      failures++;
      end_sim();
   end

   // Reports the counts and the verdict, then stops.
   task automatic end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // Main sequence.
   initial begin
      failures = 0;
      checks = 0;
      rst_n = 1'b0;
      protoBiss = 1'b0;
      errorFlag = 1'b0;
      warnFlag = 1'b0;
      turnCount = '0;
      rawAngle = '0;
      zeroOffset = '0;
      @(posedge core_clk);
      testSsi();
      testBiss(1'b1, 1'b0);
      testBiss(1'b0, 1'b1);
      end_sim();
   end

endmodule : absolute_encoder_position_port_test
